// [logic/smp_device.sv]
`timescale 1ns/1ns
// Summary of operation
// - sample serial input on rising serial clock
// - change serial output on falling serial clock
// - programmer holds reset, clock low at power-up
// - programmer waits 20ms before enable instruction
// - echo enable byte two during byte three
// - programmer sends four bytes, retries missing echo
// - load low byte before high; six-bit word
// - write-page commits buffer to seven-bit page
// - programmer waits flash delay without polling; here hold_load is always zero, so no wait
// - byte write auto-erases then writes EEPROM byte
// - EEPROM page commit alters only loaded bytes
// - read data returned during byte four
// - reset high leaves programming mode
// - 0x40/0x48 load low/high page-buffer byte
// - 0x20/0x28 read low/high program word byte
// - extended address kept for later flash accesses
// - fuse and lock readback selected by bytes
// - 0xAC writes fuses or lock from byte four
// - poll reply bit zero shows busy
// - zero programs fuse bit, keep unused ones
// - flash addresses are words, any order
// - port works only while reset held low
// - chip erase sets both arrays to ones
module smp_device
  import smp_pkg::*;
#(
  parameter int FLASH_WAIT = FLASH_PAGE_WRITE_CYC,
  parameter int EE_WAIT    = EEPROM_WRITE_CYC,
  parameter int ERASE_WAIT = CHIP_ERASE_CYC,
  parameter int FUSE_WAIT  = FUSE_WRITE_CYC,
  parameter logic [7:0]  FUSE_LO_RESET  = 8'hFF,
  parameter logic [7:0]  FUSE_HI_RESET  = 8'hFF,
  parameter logic [7:0]  FUSE_EXT_RESET = 8'hFF,
  // identification values are arbitrary
  parameter logic [23:0] SIGNATURE      = 24'h5A_A5_3C,
  parameter logic [7:0]  CALIBRATION    = 8'h80
) (
  input  wire logic  ref_clk_i,
  input  wire logic  reset_i,
  smp_link_if.device link,
  output logic       prog_mode_o,
  output logic       busy_o
);

  function automatic logic [FLASH_AW-1:0] fl_idx(input logic [7:0] ext,
                                                input logic [7:0] hi,
                                                input logic [7:0] lo);
    return {ext[0], hi[3:0], lo};
  endfunction
  function automatic logic [EE_AW-1:0] ee_idx(input logic [7:0] hi,
                                             input logic [7:0] lo);
    return {hi[1:0], lo};
  endfunction

  logic [15:0] flash_mem [2**FLASH_AW];
  logic [7:0]  ee_mem    [2**EE_AW];
  logic [7:0]  pb_lo     [PAGE_WORDS];
  logic [7:0]  pb_hi     [PAGE_WORDS];
  logic [7:0]  ee_pb     [EE_PAGE_BYTES];
  logic [7:0]  fuse_lo_reg, fuse_hi_reg, fuse_ext_reg, lock_reg;
  logic [7:0]  ext_reg;
  logic [EE_PAGE_BYTES-1:0] ee_mask_reg;
  logic        busy_reg, enabled_reg;

  //////////////////////////////////////////////////////////////////////////
  // link side, clocked by the serial clock
  logic        link_rst, frame_tgl_reg, busy_sck;
  logic [4:0]  bit_cnt_reg;
  logic [31:0] shift_reg, frame_reg;
  logic [7:0]  out_reg, reply_byte;
  logic [7:0]  b1, b2, b3;

  // reset high clears the framing so a resync pulse restarts byte one
  assign link_rst = link.rst_n | reset_i;

  always_ff @(posedge link.sck or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_reg <= 5'h00;
      shift_reg   <= 32'h0000_0000;
    end else begin
      shift_reg   <= {shift_reg[30:0], link.mosi};
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge link.sck or posedge link_rst) begin
    if (link_rst) begin
      frame_reg     <= 32'h0000_0000;
      frame_tgl_reg <= 1'b0;
    end else if (bit_cnt_reg == 5'h1F) begin
      frame_reg     <= {shift_reg[30:0], link.mosi};
      frame_tgl_reg <= ~frame_tgl_reg;
    end
  end

  smp_sync #(.W(1)) u_busy_sync (
    .clk_i (link.sck),
    .rst_i (link_rst),
    .d_i   (busy_reg),
    .q_o   (busy_sck)
  );

  assign {b1, b2, b3} = shift_reg[23:0];

  // arrays and fuses are quasi-static here: they only change while busy
  always_comb begin
    reply_byte = b3;
    case (b1)
      OP_POLL:        reply_byte = {7'h00, busy_sck};
      OP_RD_LO:       reply_byte = flash_mem[fl_idx(ext_reg, b2, b3)][7:0];
      OP_RD_HI:       reply_byte = flash_mem[fl_idx(ext_reg, b2, b3)][15:8];
      OP_EE_RD:       reply_byte = ee_mem[ee_idx(b2, b3)];
      OP_RD_FUSE:     reply_byte = (b2 == SEL_HIGH) ? fuse_ext_reg
                                                    : fuse_lo_reg;
      OP_RD_LOCK_FHI: reply_byte = (b2 == SEL_HIGH) ? fuse_hi_reg
                                                    : lock_reg;
      OP_RD_SIG:      reply_byte = (b3[1:0] == 2'h3) ? ERASED_BYTE
                      : 8'(SIGNATURE >> (5'h10 - {b3[1:0], 3'h0}));
      OP_RD_CAL:      reply_byte = CALIBRATION;
      default:        reply_byte = b3;
    endcase
  end

  // each byte boundary but the one before byte four loads the byte just
  // received (that one loads the reply), so byte two comes back while byte three shifts in
  always_ff @(negedge link.sck or posedge link_rst) begin
    if (link_rst) begin
      out_reg <= 8'h00;
    end else if (bit_cnt_reg[2:0] == 3'h0) begin
      out_reg <= (bit_cnt_reg == 5'h18) ? reply_byte : b3;
    end else begin
      out_reg <= {out_reg[6:0], 1'b0};
    end
  end

  assign link.miso = out_reg[7];

  //////////////////////////////////////////////////////////////////////////
  // core side, clocked by the cpu clock
  logic        rst_n_s, tgl_s, tgl_prev_reg, exec, do_op;
  logic [7:0]  f1, f2, f3, f4;
  logic [WAIT_W-1:0] wait_cnt_reg, wait_load;
  logic [PAGE_ADDR_BITS-1:0] page_sel;
  logic [EE_AW-1:0]  ee_addr;
  smp_sync #(.W(2)) u_core_sync (
    .clk_i (ref_clk_i),
    .rst_i (reset_i),
    .d_i   ({link.rst_n, frame_tgl_reg}),
    .q_o   ({rst_n_s, tgl_s})
  );

  assign {f1, f2, f3, f4} = frame_reg;
  // frame word is stable for 32 serial clocks after its toggle
  assign exec     = (tgl_s != tgl_prev_reg) & ~rst_n_s;
  // while a write runs, further instructions are dropped
  assign do_op    = exec & enabled_reg & ~busy_reg;
  assign page_sel = {ext_reg[0], f2[3:0], f3[7:6]};
  assign ee_addr  = ee_idx(f2, f3);

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tgl_prev_reg <= 1'b0;
    end else begin
      tgl_prev_reg <= tgl_s;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      enabled_reg <= 1'b0;
    end else if (rst_n_s) begin
      enabled_reg <= 1'b0;
    end else if (exec && f1 == OP_PROG_EN && f2 == SUB_ENABLE) begin
      enabled_reg <= 1'b1;
    end
  end

  always_comb begin
    wait_load = '0;
    case (do_op ? smp_delay_of(f1, f2) : DLY_NONE)
      DLY_FLASH:  wait_load = WAIT_W'(FLASH_WAIT);
      DLY_EEPROM: wait_load = WAIT_W'(EE_WAIT);
      DLY_ERASE:  wait_load = WAIT_W'(ERASE_WAIT);
      DLY_FUSE:   wait_load = WAIT_W'(FUSE_WAIT);
      default:    wait_load = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_cnt_reg <= '0;
      busy_reg     <= 1'b0;
    end else if (wait_load != '0) begin
      wait_cnt_reg <= wait_load;
      busy_reg     <= 1'b1;
    end else begin
      wait_cnt_reg <= (wait_cnt_reg != '0) ? wait_cnt_reg - 1'b1 : '0;
      busy_reg     <= (wait_cnt_reg > WAIT_W'(1));
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fuse_lo_reg  <= FUSE_LO_RESET;
      fuse_hi_reg  <= FUSE_HI_RESET;
      fuse_ext_reg <= FUSE_EXT_RESET;
      lock_reg     <= ERASED_BYTE;
      ext_reg      <= EXT_ADDR_RESET;
      ee_mask_reg  <= '0;
    end else if (do_op) begin
      case (f1)
        OP_LOAD_EXT:   ext_reg <= f3;
        OP_EE_LOAD:    ee_mask_reg[f3[1:0]] <= 1'b1;
        OP_EE_WR_PAGE: ee_mask_reg <= '0;
        OP_PROG_EN: begin
          case (f2)
            SUB_FUSE_LO:  fuse_lo_reg  <= f4;
            SUB_FUSE_HI:  fuse_hi_reg  <= f4;
            SUB_FUSE_EXT: fuse_ext_reg <= f4;
            // lock bits only program; chip erase or reset_i sets them back
            SUB_LOCK:     lock_reg     <= lock_reg & f4;
            SUB_ERASE:    lock_reg     <= ERASED_BYTE;
            default:      lock_reg     <= lock_reg;
          endcase
        end
        default: ext_reg <= ext_reg;
      endcase
    end
  end

  // arrays carry no reset; contents are nonvolatile in intent
  always_ff @(posedge ref_clk_i) begin
    if (do_op) begin
      case (f1)
        OP_LOAD_LO: pb_lo[f3[PAGE_WORD_BITS-1:0]] <= f4;
        OP_LOAD_HI: pb_hi[f3[PAGE_WORD_BITS-1:0]] <= f4;
        OP_WR_PAGE: begin
          for (int i = 0; i < PAGE_WORDS; i++) begin
            flash_mem[{page_sel, PAGE_WORD_BITS'(i)}] <=
              {pb_hi[i], pb_lo[i]};
          end
        end
        OP_EE_WR:   ee_mem[ee_addr] <= f4;
        OP_EE_LOAD: ee_pb[f3[1:0]] <= f4;
        OP_EE_WR_PAGE: begin
          for (int i = 0; i < EE_PAGE_BYTES; i++) begin
            if (ee_mask_reg[i]) begin
              ee_mem[{ee_addr[EE_AW-1:2], 2'(i)}] <= ee_pb[i];
            end
          end
        end
        OP_PROG_EN: begin
          if (f2 == SUB_ERASE) begin
            for (int i = 0; i < 2**FLASH_AW; i++) begin
              flash_mem[i] <= {ERASED_BYTE, ERASED_BYTE};
            end
            for (int i = 0; i < 2**EE_AW; i++) begin
              ee_mem[i] <= ERASED_BYTE;
            end
          end
        end
        default: ;
      endcase
    end
  end

  assign prog_mode_o = enabled_reg;
  assign busy_o      = busy_reg;
endmodule // smp_device

// [logic/smp_link_if.sv]
`timescale 1ns/1ns
interface smp_link_if;
  logic sck;
  logic mosi;
  logic miso;
  logic rst_n;

  modport device (
    input  sck,
    input  mosi,
    input  rst_n,
    output miso
  );

  modport programmer (
    output sck,
    output mosi,
    output rst_n,
    input  miso
  );
endinterface

// [logic/smp_pkg.sv]
package smp_pkg;

  localparam int REF_CLK_HZ = 10_000_000;

  localparam real FLASH_PAGE_WRITE_DELAY_MS = 2.6;
  localparam real EEPROM_WRITE_DELAY_MS     = 3.6;
  localparam real CHIP_ERASE_DELAY_MS       = 10.5;
  localparam real FUSE_WRITE_DELAY_MS       = 4.5;
  localparam real POWER_UP_WAIT_MS          = 20.0;

  // least times round up; the small offset keeps exact products exact
  function automatic int ms_to_cyc(input real ms);
    return int'($ceil(ms * REF_CLK_HZ / 1000.0 - 0.000001));
  endfunction

  localparam int FLASH_PAGE_WRITE_CYC = ms_to_cyc(FLASH_PAGE_WRITE_DELAY_MS);
  localparam int EEPROM_WRITE_CYC     = ms_to_cyc(EEPROM_WRITE_DELAY_MS);
  localparam int CHIP_ERASE_CYC       = ms_to_cyc(CHIP_ERASE_DELAY_MS);
  localparam int FUSE_WRITE_CYC       = ms_to_cyc(FUSE_WRITE_DELAY_MS);
  localparam int POWER_UP_WAIT_CYC    = ms_to_cyc(POWER_UP_WAIT_MS);
  localparam int RST_PULSE_MIN_CYC    = 2;
  localparam int SCK_HALF_CYC         = 4;
  localparam int WAIT_W               = 18;

  localparam int FLASH_AW       = 13;
  localparam int PAGE_WORD_BITS = 6;
  localparam int PAGE_WORDS     = 64;
  localparam int PAGE_ADDR_BITS = 7;
  localparam int EE_AW          = 10;
  localparam int EE_PAGE_BYTES  = 4;

  localparam logic [7:0] OP_PROG_EN       = 8'hAC;
  localparam logic [7:0] SUB_ENABLE       = 8'h53;
  localparam logic [7:0] SUB_ERASE        = 8'h80;
  localparam logic [7:0] SUB_LOCK         = 8'hE0;
  localparam logic [7:0] SUB_FUSE_LO      = 8'hA0;
  localparam logic [7:0] SUB_FUSE_HI      = 8'hA8;
  localparam logic [7:0] SUB_FUSE_EXT     = 8'hA4;
  localparam logic [7:0] OP_POLL          = 8'hF0;
  localparam logic [7:0] OP_LOAD_EXT      = 8'h4D;
  localparam logic [7:0] OP_LOAD_HI       = 8'h48;
  localparam logic [7:0] OP_LOAD_LO       = 8'h40;
  localparam logic [7:0] OP_EE_LOAD       = 8'hC1;
  localparam logic [7:0] OP_RD_HI         = 8'h28;
  localparam logic [7:0] OP_RD_LO         = 8'h20;
  localparam logic [7:0] OP_EE_RD         = 8'hA0;
  localparam logic [7:0] OP_RD_LOCK_FHI   = 8'h58;
  localparam logic [7:0] OP_RD_SIG        = 8'h30;
  localparam logic [7:0] OP_RD_FUSE       = 8'h50;
  localparam logic [7:0] OP_RD_CAL        = 8'h38;
  localparam logic [7:0] OP_WR_PAGE       = 8'h4C;
  localparam logic [7:0] OP_EE_WR         = 8'hC0;
  localparam logic [7:0] OP_EE_WR_PAGE    = 8'hC2;
  localparam logic [7:0] SEL_HIGH         = 8'h08;
  localparam logic [7:0] ERASED_BYTE      = 8'hFF;
  localparam logic [7:0] EXT_ADDR_RESET   = 8'h00;
  localparam logic [31:0] ENABLE_WORD     = {OP_PROG_EN, SUB_ENABLE, 16'h0000};

  typedef enum logic [2:0] {
    DLY_NONE, DLY_FLASH, DLY_EEPROM, DLY_ERASE, DLY_FUSE
  } smp_delay_t;

  function automatic smp_delay_t smp_delay_of(input logic [7:0] b1,
                                              input logic [7:0] b2);
    case (b1)
      OP_WR_PAGE:              return DLY_FLASH;
      OP_EE_WR, OP_EE_WR_PAGE: return DLY_EEPROM;
      OP_PROG_EN: begin
        case (b2)
          SUB_ERASE:                                   return DLY_ERASE;
          SUB_LOCK, SUB_FUSE_LO, SUB_FUSE_HI, SUB_FUSE_EXT: return DLY_FUSE;
          default:                                     return DLY_NONE;
        endcase
      end
      default: return DLY_NONE;
    endcase
  endfunction

endpackage

// [logic/smp_programmer.sv]
`timescale 1ns/1ns
module smp_programmer
  import smp_pkg::*;
#(
  parameter int POWER_WAIT = POWER_UP_WAIT_CYC,
  parameter int FLASH_WAIT = FLASH_PAGE_WRITE_CYC,
  parameter int EE_WAIT    = EEPROM_WRITE_CYC,
  parameter int ERASE_WAIT = CHIP_ERASE_CYC,
  parameter int FUSE_WAIT  = FUSE_WRITE_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  smp_link_if.programmer   link,
  input  wire logic        session_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [31:0] cmd_word_i,
  output logic             cmd_ready_o,
  output logic             resp_valid_o,
  output logic [7:0]       resp_echo_o,
  output logic [7:0]       resp_data_o,
  output logic             enabled_o
);

  typedef enum logic [2:0] {
    PG_OFF, PG_PULSE, PG_POWER_WAIT, PG_IDLE, PG_SHIFT, PG_HOLD
  } smp_pg_state_t;

  smp_pg_state_t     state_reg;
  logic [WAIT_W-1:0] cnt_reg;
  logic [2:0]        div_reg;
  logic [4:0]        bit_reg;
  logic [31:0]       tx_reg;
  logic [31:0]       rx_reg;
  logic              sck_reg;
  logic              rst_n_reg;
  logic              enabling_reg;
  logic              enabled_reg;
  logic              miso_s;
  logic              start;
  logic [31:0]       start_word;
  logic              half_end;
  logic              shift_done;
  logic [WAIT_W-1:0] hold_load;

  smp_sync #(.W(1)) u_miso_sync (
    .clk_i (ref_clk_i),
    .rst_i (reset_i),
    .d_i   (link.miso),
    .q_o   (miso_s)
  );

  assign cmd_ready_o = (state_reg == PG_IDLE) & enabled_reg & session_i;
  assign half_end    = (div_reg == 3'(SCK_HALF_CYC - 1));
  assign shift_done  = (state_reg == PG_SHIFT) & sck_reg & half_end &
                       (bit_reg == 5'h1F);

  always_comb begin
    start      = 1'b0;
    start_word = ENABLE_WORD;
    if (state_reg == PG_POWER_WAIT && cnt_reg == '0) begin
      start = 1'b1;
    end else if (cmd_ready_o && cmd_valid_i) begin
      start      = 1'b1;
      start_word = cmd_word_i;
    end
  end

  // hold_load decodes tx_reg after 31 shifts, so it is always zero and no timed wait runs
  always_comb begin
    case (smp_delay_of(tx_reg[31:24], tx_reg[23:16]))
      DLY_FLASH:  hold_load = WAIT_W'(FLASH_WAIT);
      DLY_EEPROM: hold_load = WAIT_W'(EE_WAIT);
      DLY_ERASE:  hold_load = WAIT_W'(ERASE_WAIT);
      DLY_FUSE:   hold_load = WAIT_W'(FUSE_WAIT);
      default:    hold_load = '0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // session sequencing

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg    <= PG_OFF;
      cnt_reg      <= '0;
      rst_n_reg    <= 1'b0;
      enabling_reg <= 1'b0;
      enabled_reg  <= 1'b0;
    end else begin
      case (state_reg)
        PG_OFF: begin
          enabled_reg <= 1'b0;
          if (session_i) begin
            rst_n_reg <= 1'b1;
            // doubled so the device's synchroniser cannot miss it
            cnt_reg   <= WAIT_W'(2 * RST_PULSE_MIN_CYC);
            state_reg <= PG_PULSE;
          end else begin
            rst_n_reg <= 1'b1;
          end
        end
        PG_PULSE: begin
          if (cnt_reg == '0) begin
            rst_n_reg <= 1'b0;
            cnt_reg   <= WAIT_W'(POWER_WAIT);
            state_reg <= PG_POWER_WAIT;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        PG_POWER_WAIT: begin
          if (cnt_reg == '0) begin
            enabling_reg <= 1'b1;
            state_reg    <= PG_SHIFT;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        PG_IDLE: begin
          if (!session_i) begin
            rst_n_reg <= 1'b1;
            state_reg <= PG_OFF;
          end else if (start) begin
            state_reg <= PG_SHIFT;
          end
        end
        PG_SHIFT: begin
          if (shift_done) begin
            enabling_reg <= 1'b0;
            if (enabling_reg && rx_reg[15:8] != SUB_ENABLE) begin
              rst_n_reg <= 1'b1;
              cnt_reg   <= WAIT_W'(2 * RST_PULSE_MIN_CYC);
              state_reg <= PG_PULSE;
            end else begin
              enabled_reg <= 1'b1;
              cnt_reg     <= hold_load;
              state_reg   <= PG_HOLD;
            end
          end
        end
        PG_HOLD: begin
          if (cnt_reg == '0) begin
            state_reg <= PG_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: state_reg <= PG_OFF;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // serial clock divider and shifter

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_reg <= 3'h0;
      bit_reg <= 5'h00;
      sck_reg <= 1'b0;
      tx_reg  <= 32'h0000_0000;
      rx_reg  <= 32'h0000_0000;
    end else if (start) begin
      div_reg <= 3'h0;
      bit_reg <= 5'h00;
      sck_reg <= 1'b0;
      tx_reg  <= start_word;
    end else if (state_reg == PG_SHIFT) begin
      if (half_end) begin
        div_reg <= 3'h0;
        sck_reg <= ~sck_reg;
        if (!sck_reg) begin
          rx_reg <= {rx_reg[30:0], miso_s};
        end else begin
          tx_reg  <= {tx_reg[30:0], 1'b0};
          bit_reg <= bit_reg + 5'h01;
        end
      end else begin
        div_reg <= div_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      resp_valid_o <= 1'b0;
      resp_echo_o  <= 8'h00;
      resp_data_o  <= 8'h00;
    end else begin
      resp_valid_o <= shift_done;
      if (shift_done) begin
        resp_echo_o <= rx_reg[15:8];
        resp_data_o <= rx_reg[7:0];
      end
    end
  end

  assign link.sck   = sck_reg;
  assign link.mosi  = tx_reg[31];
  assign link.rst_n = rst_n_reg;
  assign enabled_o  = enabled_reg;

endmodule // smp_programmer

// [logic/smp_sync.sv]
`timescale 1ns/1ns
module smp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule // smp_sync

// [verification/serial_memory_programming_port_tb_top.sv]
`timescale 1ns/1ns
module serial_memory_programming_port_tb_top;
  import smp_pkg::*;
  localparam int DW = 20;
  localparam int PW = 40;
  logic        ref_clk_i   = 1'b0;
  logic        reset_i     = 1'b1;
  logic        session_i   = 1'b0;
  logic        cmd_valid_i = 1'b0;
  logic [31:0] cmd_word_i  = 32'h00000000;
  logic        cmd_ready_o, resp_valid_o, enabled_o, prog_mode_o, busy_o;
  logic [7:0]  resp_echo_o, resp_data_o;
  wire logic [4:0] mon = {busy_o, prog_mode_o, enabled_o, resp_valid_o,
                          cmd_ready_o};
  int          n_fail = 0;
  int          checks = 0;
  // word, read mask, expected masked data; writes echo byte three
  logic [47:0] rows [35] = '{
    48'h50000000_FF_FF, 48'hACA000E2_FF_00, 48'h50000000_FF_E2,
    48'hACA800D9_FF_00, 48'h58080000_FF_D9, 48'hACA400FD_FF_00,
    48'h50080000_FF_FD, 48'hACE000FC_FF_00, 48'h58000000_FF_FC,
    48'h40000511_FF_05, 48'h48000522_FF_05, 48'h40000333_FF_03,
    48'h48000344_FF_03, 48'h4C000000_FF_00, 48'h20000500_FF_11,
    48'h28000500_FF_22, 48'h20000300_FF_33, 48'hAC800000_FF_00,
    48'h20000500_FF_FF, 48'h58000000_FF_FF, 48'h4D000100_FF_01,
    48'h40000555_FF_05, 48'h4C000000_FF_00, 48'h20000500_FF_55,
    48'h4D000000_FF_00, 48'h20000500_FF_FF, 48'hC00007A5_FF_07,
    48'hA0000700_FF_A5, 48'hC000075A_FF_07, 48'hA0000700_FF_5A,
    48'hC10001B1_FF_01, 48'hC2000400_FF_04, 48'hA0000500_FF_B1,
    48'hA0000700_FF_5A, 48'hF0000000_FF_00};

  always #50 ref_clk_i = ~ref_clk_i;

  smp_link_if link ();
  smp_device #(.FLASH_WAIT(DW), .EE_WAIT(DW), .ERASE_WAIT(DW),
    .FUSE_WAIT(DW)) i_smp_device (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .link(link), .prog_mode_o(prog_mode_o),
    .busy_o(busy_o));
  // far end wait parameters exceed the device's, but its hold_load is always zero
  smp_programmer #(.POWER_WAIT(50), .FLASH_WAIT(PW), .EE_WAIT(PW),
    .ERASE_WAIT(PW), .FUSE_WAIT(PW)) i_smp_programmer (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .link(link),
    .session_i(session_i), .cmd_valid_i(cmd_valid_i),
    .cmd_word_i(cmd_word_i), .cmd_ready_o(cmd_ready_o),
    .resp_valid_o(resp_valid_o), .resp_echo_o(resp_echo_o),
    .resp_data_o(resp_data_o), .enabled_o(enabled_o));
  smp_link_props #(.POWER_WAIT(50)) i_smp_link_props (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .sck(link.sck),
    .mosi(link.mosi), .miso(link.miso), .rst_n(link.rst_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_lvl(input int sel, input logic v, input int lim);
    int i;
    for (i = 0; mon[sel] !== v && i < lim; i++) begin
      @(posedge ref_clk_i);
      #1;
    end
    if (mon[sel] !== v) begin
      n_fail++;
      $display("mismatch at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask

  task automatic run(input logic [31:0] w, output logic [7:0] echo,
                     output logic [7:0] data);
    wait_lvl(0, 1'b1, 2000);
    cmd_valid_i = 1'b1;
    cmd_word_i  = w;
    @(posedge ref_clk_i);
    #1;
    cmd_valid_i = 1'b0;
    wait_lvl(1, 1'b1, 400);
    echo = resp_echo_o;
    data = resp_data_o;
  endtask

  initial begin
    logic [7:0] e;
    logic [7:0] d;
    repeat (8) @(posedge ref_clk_i);
    #1;
    check({7'h00, prog_mode_o}, 8'h00);
    check({7'h00, busy_o}, 8'h00);
    reset_i   = 1'b0;
    session_i = 1'b1;
    wait_lvl(2, 1'b1, 2000);
    check({7'h00, prog_mode_o}, 8'h01);
    $display("test enable done");
    for (int i = 0; i < 35; i++) begin
      run(rows[i][47:16], e, d);
      check(d & rows[i][15:8], rows[i][7:0]);
      check(e, rows[i][39:32]);
    end
    $display("test table done");
    run(32'hC0000977, e, d);
    wait_lvl(4, 1'b1, 10);
    check({7'h00, busy_o}, 8'h01);
    $display("test busy done");
    session_i = 1'b0;
    wait_lvl(3, 1'b0, 200);
    check({7'h00, prog_mode_o}, 8'h00);
    check({7'h00, enabled_o}, 8'h00);
    $display("test release done");
    session_i = 1'b1;
    wait_lvl(2, 1'b1, 2000);
    run(32'hA0000900, e, d);
    check(d, 8'h77);
    $display("test resume done");
    give_verdict();
  end
endmodule // serial_memory_programming_port_tb_top

// [verification/smp_link_props.sv]
`timescale 1ns/1ns
module smp_link_props #(
  parameter int POWER_WAIT = 50
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic rst_n
);
  logic [15:0] low_cnt_reg;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // saturates so a long session never wraps back below the bound
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_cnt_reg <= 16'h0000;
    end else if (rst_n) begin
      low_cnt_reg <= 16'h0000;
    end else if (low_cnt_reg != 16'hFFFF) begin
      low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_sck_high_time: assert property ($rose(sck) |-> sck [*3])
    else $error("serial clock high phase too short");
  a_sck_low_time: assert property ($fell(sck) |-> !sck [*3])
    else $error("serial clock low phase too short");
  a_mosi_at_rise: assert property ($rose(sck) |-> $stable(mosi) [*3])
    else $error("serial input moved around rising clock");
  a_miso_on_fall: assert property (!rst_n && $past(!rst_n)
    && $changed(miso) |-> $fell(sck))
    else $error("serial output moved off falling clock");
  a_idle_clock_rst: assert property (rst_n |-> !sck)
    else $error("serial clock active while reset pin high");
  a_rst_pulse_len: assert property ($rose(rst_n) |-> rst_n [*2])
    else $error("reset pin pulse too short");
  a_power_up_wait: assert property ($rose(sck)
    |-> int'(low_cnt_reg) >= POWER_WAIT)
    else $error("first serial clock too soon after reset low");
  a_miso_quiet_run: assert property (rst_n && $past(rst_n) |-> !miso)
    else $error("serial output active outside programming");

  c_reset_pulse: cover property ($rose(rst_n));
  c_session: cover property ($fell(rst_n) ##1 !rst_n);
  c_read_data: cover property ($rose(miso));
endmodule // smp_link_props
